/* core/irq_pin_driver.sv */
// one interrupt pin output stage: polarity and push-pull or open-drain drive
module irq_pin_driver (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // control
   input  wire logic active_in,
   input  wire logic pol_high,
   input  wire logic pin_drive_select,
   // pin
   output logic      pin_out,
   output logic      pin_oe
);
   wire level_w = pol_high ? active_in : ~active_in;
   wire oe_w    = pin_drive_select ? (level_w == 1'b0) : 1'b1;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_out <= 1'b1;
         pin_oe  <= !pin_drive_select;
      end else begin
         pin_out <= pin_drive_select ? 1'b0 : level_w;
         pin_oe  <= oe_w;
      end
   end

   a_od_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pin_drive_select && level_w |=> !pin_oe)
      else $error("open-drain pin driven while released");
endmodule // irq_pin_driver

/* core/sensor_interrupt_enable_routing.sv */
// interrupt enable, routing and pin combining logic
`include "irq_route_defines.svh"

// What this block does
// - A source flag reaches a pin only while its enable bit is one.
// - The enable register at 0x2d holds one read/write bit per source, reset to zero.
// - The routing register at 0x2e uses the same bit order, read/write, reset to zero.
// - A routing bit of zero steers the source to the second pin, one to the first.
// - Each enabled source goes to exactly one of the two pins.
// - All enabled sources steered to a pin are combined by OR.
// - Magnetic sources carry their own enable and routing yet join the same OR.
// - A polarity control makes both pins active low at zero and active high at one.
// - A drive control makes both pins push-pull at zero and open-drain at one.
// - An enabled auto-sleep interrupt is raised on each mode change and cleared by reading the mode register.
module sensor_interrupt_enable_routing (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_n,
   // register port
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   // event flags from functional blocks, bit 7 unused (auto-sleep made here)
   input  wire irq_route_pkg::src_vec_t src_flags,
   input  wire logic                 sleep_mode,
   // magnetic sources and their own enable and routing
   input  wire irq_route_pkg::mag_vec_t mag_flags,
   input  wire irq_route_pkg::mag_vec_t mag_enable,
   input  wire irq_route_pkg::mag_vec_t mag_route_first,
   // pin controls
   input  wire logic                 pol_high,
   input  wire logic                 pin_drive_select,
   // interrupt pins
   output logic                      irq_pin_first_out,
   output logic                      irq_pin_first_oe,
   output logic                      irq_pin_second_out,
   output logic                      irq_pin_second_oe,
   // auto-sleep flag state
   output logic                      aslp_flag
);
   // ************************************************
   // registers
   // ************************************************
   irq_route_pkg::src_vec_t interrupt_enable_mask_r;
   irq_route_pkg::src_vec_t interrupt_pin_routing_r;
   logic                    aslp_r;
   logic                    sleep_mode_r;

   wire wr_en_w    = reg_wr && (reg_addr == `ADDR_INT_ENABLE_MASK);
   wire wr_route_w = reg_wr && (reg_addr == `ADDR_INT_PIN_ROUTING);
   wire rd_mode_w  = reg_rd && (reg_addr == `ADDR_SYSTEM_MODE);
   wire mode_chg_w = sleep_mode != sleep_mode_r;
   wire aslp_en_w  = interrupt_enable_mask_r[`SRC_ASLP_BIT];
   wire aslp_nxt   = (aslp_en_w && mode_chg_w) ? 1'b1 : (rd_mode_w ? 1'b0 : aslp_r);

   wire [7:0] rdata_nxt = (reg_addr == `ADDR_INT_ENABLE_MASK) ? interrupt_enable_mask_r :
                          (reg_addr == `ADDR_INT_PIN_ROUTING) ? interrupt_pin_routing_r :
                          (reg_addr == `ADDR_SYSTEM_MODE)     ? {7'h00, sleep_mode_r} : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         interrupt_enable_mask_r <= `RST_INT_ENABLE_MASK;
         interrupt_pin_routing_r <= `RST_INT_PIN_ROUTING;
         aslp_r                  <= 1'b0;
         sleep_mode_r            <= 1'b0;
         reg_rdata               <= 8'h00;
      end else begin
         if (wr_en_w) interrupt_enable_mask_r <= reg_wdata;
         if (wr_route_w) interrupt_pin_routing_r <= reg_wdata;
         aslp_r       <= aslp_nxt;
         sleep_mode_r <= sleep_mode;
         reg_rdata    <= rdata_nxt;
      end
   end

   // ************************************************
   // gating, routing and combining
   // ************************************************
   wire [7:0] flags_w   = {aslp_r, src_flags[6:0]};
   wire [7:0] gated_w   = flags_w & interrupt_enable_mask_r;
   wire [7:0] to_first  = gated_w & interrupt_pin_routing_r;
   wire [7:0] to_second = gated_w & ~interrupt_pin_routing_r;
   wire [1:0] mag_g     = mag_flags & mag_enable;
   wire first_act_w     = (|to_first) | (|(mag_g & mag_route_first));
   wire second_act_w    = (|to_second) | (|(mag_g & ~mag_route_first));
   logic first_act_r;
   logic second_act_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         first_act_r  <= 1'b0;
         second_act_r <= 1'b0;
         aslp_flag    <= 1'b0;
      end else begin
         first_act_r  <= first_act_w;
         second_act_r <= second_act_w;
         aslp_flag    <= aslp_nxt;
      end
   end

   irq_pin_driver u_first (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .active_in        (first_act_r),
      .pol_high         (pol_high),
      .pin_drive_select (pin_drive_select),
      .pin_out          (irq_pin_first_out),
      .pin_oe           (irq_pin_first_oe)
   );

   irq_pin_driver u_second (
      .ref_clk          (ref_clk),
      .rst_n            (rst_n),
      .active_in        (second_act_r),
      .pol_high         (pol_high),
      .pin_drive_select (pin_drive_select),
      .pin_out          (irq_pin_second_out),
      .pin_oe           (irq_pin_second_oe)
   );

   // ************************************************
   // checks
   // ************************************************
   sequence s_pp_low_held;
      !pol_high && !pin_drive_select;
   endsequence
   sequence s_first_src_pp_low;
      (|to_first) && !pol_high && !pin_drive_select;
   endsequence
   sequence s_second_src_pp_low;
      (|to_second) && !pol_high && !pin_drive_select;
   endsequence
   sequence s_second_quiet_two;
      !second_act_w ##1 !second_act_w;
   endsequence

   a_disabled_silent: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (interrupt_enable_mask_r == 8'h00 && mag_enable == 2'b00) |=> !first_act_r && !second_act_r)
      else $error("disabled sources reached a pin");
   a_enable_reset: assert property (@(posedge ref_clk)
      !rst_n |=> interrupt_enable_mask_r == 8'h00 && interrupt_pin_routing_r == 8'h00)
      else $error("control registers not cleared by reset");
   a_enable_stores: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en_w |=> interrupt_enable_mask_r == $past(reg_wdata))
      else $error("enable write lost");
   a_enable_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !wr_en_w |=> $stable(interrupt_enable_mask_r))
      else $error("enable register changed without a write");
   a_rdata_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_addr == `ADDR_INT_ENABLE_MASK) |=> reg_rdata == $past(interrupt_enable_mask_r))
      else $error("enable readback wrong");

   a_write_stores: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_route_w |=> interrupt_pin_routing_r == $past(reg_wdata))
      else $error("routing write lost");
   a_route_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !wr_route_w |=> $stable(interrupt_pin_routing_r))
      else $error("routing register changed without a write");
   a_rdata_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_addr == `ADDR_INT_PIN_ROUTING) |=> reg_rdata == $past(interrupt_pin_routing_r))
      else $error("routing readback wrong");

   a_route_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|to_first) |=> first_act_r)
      else $error("first pin missed a routed source");
   a_route_excl: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mag_g == 2'b00 && to_first == 8'h00) |=> !first_act_r)
      else $error("first pin raised without a routed source");
   a_second_excl: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (mag_g == 2'h0 && to_second == 8'h00) |=> !second_act_r)
      else $error("second pin raised without a routed source");
   a_or_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|to_second) |=> second_act_r)
      else $error("second pin missed an OR term");
   a_mag_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(mag_g & mag_route_first)) |=> first_act_r)
      else $error("magnetic source missed the first pin");
   a_mag_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|(mag_g & ~mag_route_first)) |=> second_act_r)
      else $error("magnetic source missed the second pin");

   a_pol_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pol_high && !pin_drive_select && first_act_r ##1 !pol_high |-> !irq_pin_first_out)
      else $error("active low pin not low");
   a_pol_high_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pol_high && !pin_drive_select && first_act_r |=> irq_pin_first_out)
      else $error("active high pin not high");
   a_pol_low_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !pol_high && !pin_drive_select && second_act_r |=> !irq_pin_second_out)
      else $error("active low second pin not low");
   a_pins_reset: assert property (@(posedge ref_clk)
      !rst_n && !pin_drive_select |=>
         irq_pin_first_out && irq_pin_first_oe && irq_pin_second_out && irq_pin_second_oe)
      else $error("push-pull pins not inactive after reset");
   a_pins_reset_od: assert property (@(posedge ref_clk)
      !rst_n && pin_drive_select |=> !irq_pin_first_oe && !irq_pin_second_oe)
      else $error("open-drain pins driven during reset");
   a_od_low_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pin_drive_select |=> !irq_pin_first_out && !irq_pin_second_out)
      else $error("open-drain pin driven high");

   a_aslp_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      aslp_en_w && mode_chg_w |=> aslp_r)
      else $error("mode change did not raise auto-sleep flag");
   a_aslp_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_mode_w && !(aslp_en_w && mode_chg_w) |=> !aslp_r)
      else $error("mode read did not clear auto-sleep flag");
   a_aslp_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !rd_mode_w && !(aslp_en_w && mode_chg_w) |=> aslp_r == $past(aslp_r))
      else $error("auto-sleep flag changed without cause");
   a_rdata_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (reg_addr == `ADDR_SYSTEM_MODE) |=> reg_rdata == {7'h00, $past(sleep_mode_r)})
      else $error("mode readback wrong");

   a_level_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !first_act_w ##1 !first_act_w |=> !first_act_r)
      else $error("pin level held after sources cleared");
   a_first_chain: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_first_src_pp_low ##1 s_pp_low_held |=> !irq_pin_first_out)
      else $error("first pin did not follow its source");
   a_second_chain: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_second_src_pp_low ##1 s_pp_low_held |=> !irq_pin_second_out)
      else $error("second pin did not follow its source");
   a_second_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_second_quiet_two |=> !second_act_r)
      else $error("second pin level held after sources cleared");
endmodule // sensor_interrupt_enable_routing

/* inc/irq_route_defines.svh */
// constants for the interrupt enable and routing block
`ifndef IRQ_ROUTE_DEFINES_SVH
`define IRQ_ROUTE_DEFINES_SVH
`define ADDR_INT_ENABLE_MASK   8'h2d
`define ADDR_INT_PIN_ROUTING   8'h2e
`define ADDR_SYSTEM_MODE       8'h0b
`define RST_INT_ENABLE_MASK    8'h00
`define RST_INT_PIN_ROUTING    8'h00
`define SRC_ASLP_BIT           7
`define SRC_FIFO_BIT           6
`define SRC_TRANS_BIT          5
`define SRC_ORIENT_BIT         4
`define SRC_PULSE_BIT          3
`define SRC_FFMT_BIT           2
`define SRC_AVECM_BIT          1
`define SRC_DRDY_BIT           0
`endif

/* inc/irq_route_pkg.sv */
// types for the interrupt enable and routing block
package irq_route_pkg;
   typedef logic [7:0] src_vec_t;
   typedef logic [1:0] mag_vec_t;
endpackage

/* tb/irq_host_model.sv */
// host side of the interrupt pins: pull-up wires and request sensing
module irq_host_model (
   // pin polarity seen by the host
   input  wire logic pol_high,
   // pins from the device
   input  wire logic first_out,
   input  wire logic first_oe,
   input  wire logic second_out,
   input  wire logic second_oe,
   // sensed requests
   output logic      irq_first,
   output logic      irq_second
);
   timeunit 1ns;
   timeprecision 1ps;
   // released pins float up to the pull-up level
   wire logic first_lvl  = first_oe ? first_out : 1'b1;
   wire logic second_lvl = second_oe ? second_out : 1'b1;
   assign irq_first  = (first_lvl === pol_high);
   assign irq_second = (second_lvl === pol_high);
endmodule // irq_host_model

/* tb/sensor_interrupt_enable_routing_tb_top.sv */
// testbench for the interrupt enable and routing block
module sensor_interrupt_enable_routing_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // row: enable, routing, flags, then mag enable, mag route, mag flags, {first, second}
   typedef struct packed {logic [7:0] en, rt, fl; logic [1:0] me, mr, mf, ex;} row_t;
   logic ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sleep_mode = 0, pol_high = 0, pin_drive_select = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   irq_route_pkg::src_vec_t src_flags = 8'h00;
   irq_route_pkg::mag_vec_t mag_flags = 2'h0, mag_enable = 2'h0, mag_route_first = 2'h0;
   logic irq_pin_first_out, irq_pin_first_oe, irq_pin_second_out, irq_pin_second_oe, aslp_flag, irq_first, irq_second;
   int n_mismatch = 0, n_tests = 0;
   row_t rows [9] = '{32'h01000101, 32'h01010102, 32'h00017f00, 32'h7e0a0a02, 32'h7f0f3001,
                      32'h7f557f03, 32'h00000056, 32'h0000008d, 32'h80808000};
   sensor_interrupt_enable_routing sensor_interrupt_enable_routing_inst (.ref_clk, .rst_n, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .src_flags, .sleep_mode, .mag_flags, .mag_enable, .mag_route_first,
      .pol_high, .pin_drive_select, .irq_pin_first_out, .irq_pin_first_oe, .irq_pin_second_out,
      .irq_pin_second_oe, .aslp_flag);
   irq_host_model irq_host_model_inst (.pol_high, .first_out(irq_pin_first_out), .first_oe(irq_pin_first_oe),
      .second_out(irq_pin_second_out), .second_oe(irq_pin_second_oe), .irq_first, .irq_second);
   // ****************
   // tasks
   // ****************
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, v);
      cyc(1);
      reg_wr = 1;
      reg_addr = a;
      reg_wdata = v;
      cyc(1);
      reg_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      cyc(1);
      reg_rd = 1;
      reg_addr = a;
      cyc(1);
      reg_rd = 0;
      v = reg_rdata;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ****************
   // stimulus
   // ****************
   initial forever #20 ref_clk = ~ref_clk;
   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      cyc(6);
      rst_n = 1;
      chk("reset pins", 8'h0f, {irq_pin_first_out, irq_pin_first_oe, irq_pin_second_out, irq_pin_second_oe});
      rd(8'h2d, d); chk("enable reset", 8'h00, d);
      rd(8'h2e, d); chk("routing reset", 8'h00, d);
      $display("reset values done");
      foreach (rows[i]) begin
         wr(8'h2d, rows[i].en);
         wr(8'h2e, rows[i].rt);
         rd(8'h2d, d); chk("enable readback", rows[i].en, d);
         rd(8'h2e, d); chk("routing readback", rows[i].rt, d);
         {src_flags, mag_enable, mag_route_first, mag_flags} = {rows[i].fl, rows[i].me, rows[i].mr, rows[i].mf};
         cyc(3);
         chk("pins", {6'h0, rows[i].ex}, {6'h0, irq_first, irq_second});
         {src_flags, mag_flags} = 10'h000;
         cyc(3);
         chk("pins idle", 8'h00, {6'h0, irq_first, irq_second});
      end
      $display("routing rows done");
      wr(8'h2f, 8'hff);
      rd(8'h2f, d); chk("unmapped read", 8'h00, d);
      wr(8'h2d, 8'h80);
      wr(8'h2e, 8'h80);
      sleep_mode = 1;
      cyc(3);
      chk("sleep raise", 8'h03, {6'h0, aslp_flag, irq_first});
      rd(8'h0b, d); chk("mode read", 8'h01, d);
      cyc(3);
      chk("sleep clear", 8'h00, {6'h0, aslp_flag, irq_first});
      reg_rd = 1;
      reg_addr = 8'h0b;
      sleep_mode = 0;
      cyc(1);
      reg_rd = 0;
      chk("sleep set wins", 8'h01, {7'h0, aslp_flag});
      rd(8'h0b, d);
      chk("wake mode read", 8'h00, d);
      chk("wake clear", 8'h00, {7'h0, aslp_flag});
      $display("auto-sleep done");
      wr(8'h2d, 8'h01);
      wr(8'h2e, 8'h01);
      src_flags = 8'h01;
      pol_high = 1;
      cyc(3);
      chk("high polarity", 8'h03, {6'h0, irq_pin_first_out, irq_pin_first_oe});
      pol_high = 0;
      pin_drive_select = 1;
      cyc(3);
      chk("open drain on", 8'h01, {6'h0, irq_pin_first_out, irq_pin_first_oe});
      src_flags = 8'h00;
      cyc(3);
      chk("open drain off", 8'h00, {7'h0, irq_pin_first_oe});
      $display("pin drive done");
      rst_n = 0;
      cyc(2);
      rst_n = 1;
      chk("od reset pins", 8'h0a,
          {irq_pin_first_out, irq_pin_first_oe, irq_pin_second_out, irq_pin_second_oe});
      rd(8'h2d, d); chk("second reset", 8'h00, d);
      $display("second reset done");
      wrap_up();
   end
endmodule // sensor_interrupt_enable_routing_tb_top
